// [logic/edge_sync.sv]
`timescale 1ns/10ps
module edge_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Raw asynchronous levels and their filtered copy
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level_q
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // Three-stage chain; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         meta_q <= async_in;
         s2_q <= meta_q;
         s3_q <= s2_q;
      end
   end

   // Level moves only once stages two and three agree, masking runts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q <= '0;
      end else begin
         level_q <= (s3_q & ~(s2_q ^ s3_q)) | (level_q & (s2_q ^ s3_q));
      end
   end

endmodule

// [logic/reciprocal_gate_counter.sv]
`timescale 1ns/10ps
`include "gate_counter_map.svh"
module reciprocal_gate_counter #(
   parameter int CNT_W = 32
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Conditioned channels and external arm
   input wire logic input_one,
   input wire logic input_two,
   input wire logic ext_arm,
   // Edge interpolator discharge indications
   input wire logic open_discharge,
   input wire logic close_discharge,
   // Edge interpolator charge pulses
   output logic start_pulse,
   output logic stop_pulse,
   // Gate and event indications
   output logic gate_open,
   output logic evt_gate_opened,
   output logic evt_gate_closed,
   output logic evt_rollover,
   output logic evt_done
);

   localparam logic [7:0] REF_DIV = 8'(`REF_DIV_CYC);
   localparam logic [7:0] OPEN_TICKS = 8'(`OPEN_PULSE_TICKS);

   gate_counter_pkg::gate_state_t state_q;
   gate_counter_pkg::meas_func_t func;
   logic [`CTRL_WIDTH-1:0] ctrl_q;
   logic [31:0] gate_time_q;
   logic [15:0] cal_width_q;
   logic [3:0] sticky_q;
   logic [4:0] lvl;
   logic [4:0] prev_q;
   logic [7:0] div_q;
   logic ref_tick_q;
   logic [CNT_W-1:0] evt_cnt_q;
   logic [CNT_W-1:0] ref_cnt_q;
   logic [31:0] gate_tmr_q;
   logic [1:0] pulse_q;
   logic [7:0] ptick_q [2];
   logic [7:0] plen_q [2];
   logic [1:0] run_q;
   logic [1:0] seen_q;
   logic [1:0] tdone_q;
   logic [CNT_W-1:0] tally_q [2];
   logic [CNT_W-1:0] cal_q [4];
   logic cal_phase_q;
   logic cal_fire_q;
   logic ch_a;
   logic ch_b;
   logic pa;
   logic pb;
   logic edge_a;
   logic edge_b;
   logic open_edge;
   logic close_edge;
   logic evt_edge;
   logic ti_mode;
   logic period_done;
   logic counting;
   logic do_open;
   logic do_close;
   logic cal_take;
   logic [1:0] fire;
   logic [7:0] fire_len;
   logic [1:0] disch;
   logic wr_acc;
   logic [2:0] cmd;
   logic [3:0] sts_set;
   logic [31:0] rd_data;
   logic rd_ok;
   logic roll;

   function automatic logic slope_hit(input logic now, input logic was, input logic rising);
      return rising ? (now & ~was) : (~now & was);
   endfunction

   // Asynchronous inputs filtered before any use
   edge_sync #(
      .WIDTH(5)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({close_discharge, open_discharge, ext_arm, input_two, input_one}),
      .level_q(lvl)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= '0;
      end else begin
         prev_q <= lvl;
      end
   end

   // Front end: common mode replaces channel two with input one
   assign ch_a = lvl[0];
   assign ch_b = ctrl_q[`CTRL_COMMON] ? lvl[0] : lvl[1];
   assign pa = prev_q[0];
   assign pb = ctrl_q[`CTRL_COMMON] ? prev_q[0] : prev_q[1];
   assign edge_a = slope_hit(ch_a, pa, ctrl_q[`CTRL_SLOPE_ONE]);
   assign edge_b = slope_hit(ch_b, pb, ctrl_q[`CTRL_SLOPE_TWO]);
   assign func = gate_counter_pkg::meas_func_t'(ctrl_q[`CTRL_FUNC_HI:`CTRL_FUNC_LO]);
   assign disch = lvl[4:3];

   // Router: open, close and event sources per function
   always_comb begin
      open_edge = edge_a;
      close_edge = edge_a;
      evt_edge = edge_a;
      ti_mode = 1'b0;
      case (func)
         gate_counter_pkg::FN_FREQ_ONE, gate_counter_pkg::FN_PERIOD_ONE: begin
            evt_edge = edge_a;
         end
         gate_counter_pkg::FN_FREQ_TWO, gate_counter_pkg::FN_PERIOD_TWO: begin
            open_edge = edge_b;
            close_edge = edge_b;
            evt_edge = edge_b;
         end
         gate_counter_pkg::FN_TI_ONE_TWO: begin
            close_edge = edge_b;
            ti_mode = 1'b1;
         end
         gate_counter_pkg::FN_TI_TWO_ONE: begin
            open_edge = edge_b;
            evt_edge = edge_b;
            ti_mode = 1'b1;
         end
         default: begin
            open_edge = edge_a;
         end
      endcase
   end

   // 10 MHz reference tick from the 100 MHz clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 8'h00;
         ref_tick_q <= 1'b0;
      end else begin
         ref_tick_q <= (div_q == REF_DIV - 8'h01);
         div_q <= (div_q == REF_DIV - 8'h01) ? 8'h00 : div_q + 8'h01;
      end
   end

   // Gate period end: none needed for intervals, else timer or arm pin
   always_comb begin
      if (ti_mode) begin
         period_done = 1'b1;
      end else if (ctrl_q[`CTRL_GATE_EXT]) begin
         period_done = ~lvl[2];
      end else begin
         period_done = (gate_tmr_q >= gate_time_q);
      end
   end

   // Transitions only on measured-signal edges, never on the reference
   assign do_open = (state_q == gate_counter_pkg::ST_WAIT_OPEN) &&
                    ctrl_q[`CTRL_ARM_START] && open_edge;
   assign do_close = (state_q == gate_counter_pkg::ST_WAIT_CLOSE) &&
                     ctrl_q[`CTRL_ARM_STOP] && close_edge;
   assign counting = (state_q == gate_counter_pkg::ST_GATE) ||
                     (state_q == gate_counter_pkg::ST_WAIT_CLOSE);
   assign cal_take = (state_q == gate_counter_pkg::ST_CAL) && !cal_fire_q &&
                     (&tdone_q) && !(|pulse_q);
   assign wr_acc = psel && penable && pready && pwrite;
   assign cmd = (wr_acc && paddr == `OFS_CMD) ? pwdata[2:0] : 3'h0;

   // Measurement sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= gate_counter_pkg::ST_IDLE;
         cal_phase_q <= 1'b0;
         cal_fire_q <= 1'b0;
      end else begin
         cal_fire_q <= 1'b0;
         if (cmd[`CMD_ABORT]) begin
            state_q <= gate_counter_pkg::ST_IDLE;
         end else begin
            case (state_q)
               gate_counter_pkg::ST_IDLE, gate_counter_pkg::ST_DONE: begin
                  if (cmd[`CMD_GO]) begin
                     state_q <= gate_counter_pkg::ST_WAIT_OPEN;
                  end else if (cmd[`CMD_CAL]) begin
                     state_q <= gate_counter_pkg::ST_CAL;
                     cal_phase_q <= 1'b0;
                     cal_fire_q <= 1'b1;
                  end
               end
               gate_counter_pkg::ST_WAIT_OPEN: begin
                  if (do_open) begin
                     state_q <= gate_counter_pkg::ST_GATE;
                  end
               end
               gate_counter_pkg::ST_GATE: begin
                  if (period_done) begin
                     state_q <= gate_counter_pkg::ST_WAIT_CLOSE;
                  end
               end
               gate_counter_pkg::ST_WAIT_CLOSE: begin
                  if (do_close) begin
                     state_q <= gate_counter_pkg::ST_INTERP;
                  end
               end
               gate_counter_pkg::ST_INTERP: begin
                  if (&tdone_q) begin
                     state_q <= gate_counter_pkg::ST_DONE;
                  end
               end
               gate_counter_pkg::ST_CAL: begin
                  if (cal_take) begin
                     if (cal_phase_q) begin
                        state_q <= gate_counter_pkg::ST_DONE;
                     end else begin
                        cal_phase_q <= 1'b1;
                        cal_fire_q <= 1'b1;
                     end
                  end
               end
               default: begin
                  state_q <= gate_counter_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // Event and reference counters; frozen outside the gate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_cnt_q <= '0;
         ref_cnt_q <= '0;
         gate_tmr_q <= 32'h0;
      end else if (cmd[`CMD_GO] && (state_q == gate_counter_pkg::ST_IDLE ||
                                    state_q == gate_counter_pkg::ST_DONE)) begin
         evt_cnt_q <= '0;
         ref_cnt_q <= '0;
         gate_tmr_q <= 32'h0;
      end else if (counting) begin
         evt_cnt_q <= evt_cnt_q + CNT_W'(evt_edge);
         ref_cnt_q <= ref_cnt_q + CNT_W'(ref_tick_q);
         gate_tmr_q <= gate_tmr_q + 32'(ref_tick_q);
      end
   end

   assign roll = counting && ((evt_edge && (&evt_cnt_q)) || (ref_tick_q && (&ref_cnt_q)));

   // Open path fires at gate opening, close path at closure
   assign fire[0] = do_open || cal_fire_q;
   assign fire[1] = do_close || cal_fire_q;
   assign fire_len = (state_q == gate_counter_pkg::ST_CAL) ?
                     (cal_phase_q ? cal_width_q[15:8] : cal_width_q[7:0]) : OPEN_TICKS;

   // Charge pulse and discharge tally, one per path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_q <= 2'b00;
         run_q <= 2'b00;
         seen_q <= 2'b00;
         tdone_q <= 2'b11;
         for (int i = 0; i < 2; i++) begin
            ptick_q[i] <= 8'h00;
            plen_q[i] <= 8'h00;
            tally_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (fire[i]) begin
               pulse_q[i] <= 1'b1;
               ptick_q[i] <= 8'h00;
               plen_q[i] <= fire_len;
               tally_q[i] <= '0;
               run_q[i] <= 1'b0;
               seen_q[i] <= 1'b0;
               tdone_q[i] <= 1'b0;
            end else if (pulse_q[i]) begin
               if (ref_tick_q) begin
                  ptick_q[i] <= ptick_q[i] + 8'h01;
                  if (ptick_q[i] + 8'h01 == plen_q[i]) begin
                     pulse_q[i] <= 1'b0;
                     run_q[i] <= 1'b1;
                  end
               end
            end else if (run_q[i]) begin
               if (disch[i]) begin
                  tally_q[i] <= tally_q[i] + CNT_W'(1);
                  seen_q[i] <= 1'b1;
               end else if (seen_q[i]) begin
                  run_q[i] <= 1'b0;
                  tdone_q[i] <= 1'b1;
               end
            end
         end
      end
   end

   // Calibration captures: index is width phase then path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            cal_q[i] <= '0;
         end
      end else if (cal_take) begin
         cal_q[{cal_phase_q, 1'b0}] <= tally_q[0];
         cal_q[{cal_phase_q, 1'b1}] <= tally_q[1];
      end
   end

   // Event pulses and gate level to the outside
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_gate_opened <= 1'b0;
         evt_gate_closed <= 1'b0;
         evt_rollover <= 1'b0;
         evt_done <= 1'b0;
         gate_open <= 1'b0;
      end else begin
         evt_gate_opened <= do_open;
         evt_gate_closed <= do_close;
         evt_rollover <= roll;
         evt_done <= (state_q != gate_counter_pkg::ST_DONE) && sts_set[`STS_DONE];
         gate_open <= (counting && !do_close) || do_open;
      end
   end

   assign sts_set[`STS_OPENED] = do_open;
   assign sts_set[`STS_CLOSED] = do_close;
   assign sts_set[`STS_ROLL] = roll;
   assign sts_set[`STS_DONE] = ((state_q == gate_counter_pkg::ST_INTERP) && (&tdone_q)) ||
                               (cal_take && cal_phase_q);

   // Sticky flags: write one clears, a same-cycle set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sticky_q <= 4'h0;
      end else if (wr_acc && paddr == `OFS_STATUS) begin
         sticky_q <= (sticky_q & ~pwdata[3:0]) | sts_set;
      end else begin
         sticky_q <= sticky_q | sts_set;
      end
   end

   // Software-written configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `RST_CTRL;
         gate_time_q <= `RST_GATE_TIME;
         cal_width_q <= `RST_CAL_WIDTH;
      end else if (wr_acc) begin
         case (paddr)
            `OFS_CTRL: ctrl_q <= pwdata[`CTRL_WIDTH-1:0];
            `OFS_GATE_TIME: gate_time_q <= pwdata;
            `OFS_CAL_WIDTH: cal_width_q <= pwdata[15:0];
            default: begin
            end
         endcase
      end
   end

   // Read decode; counters are 32 bits wide by default
   always_comb begin
      rd_data = 32'h0;
      rd_ok = 1'b1;
      case (paddr)
         `OFS_CTRL: rd_data = 32'(ctrl_q);
         `OFS_CMD: rd_data = 32'h0;
         `OFS_GATE_TIME: rd_data = gate_time_q;
         `OFS_CAL_WIDTH: rd_data = 32'(cal_width_q);
         `OFS_STATUS: rd_data = {16'h0, 1'b0, state_q, 4'h0, sticky_q};
         `OFS_EVENT_CNT: rd_data = 32'(evt_cnt_q);
         `OFS_REF_CNT: rd_data = 32'(ref_cnt_q);
         `OFS_OPEN_TALLY: rd_data = 32'(tally_q[0]);
         `OFS_CLOSE_TALLY: rd_data = 32'(tally_q[1]);
         8'h24: rd_data = 32'(cal_q[0]);
         8'h28: rd_data = 32'(cal_q[1]);
         8'h2c: rd_data = 32'(cal_q[2]);
         `OFS_CAL_LAST: rd_data = 32'(cal_q[3]);
         default: rd_ok = 1'b0;
      endcase
   end

   // No wait state: data and ready prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         // Error only beside ready, so a stale flag never outlives its transfer
         pslverr <= psel && !penable && (!rd_ok || (paddr[1:0] != 2'b00));
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h0 : rd_data;
         end
      end
   end

   assign start_pulse = pulse_q[0];
   assign stop_pulse = pulse_q[1];

endmodule

// [pkg/gate_counter_map.svh]
`ifndef GATE_COUNTER_MAP_SVH
`define GATE_COUNTER_MAP_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_GATE_TIME 8'h08
`define OFS_CAL_WIDTH 8'h0c
`define OFS_STATUS 8'h10
`define OFS_EVENT_CNT 8'h14
`define OFS_REF_CNT 8'h18
`define OFS_OPEN_TALLY 8'h1c
`define OFS_CLOSE_TALLY 8'h20
`define OFS_CAL_BASE 8'h24
`define OFS_CAL_LAST 8'h30

// Control field positions
`define CTRL_ARM_START 0
`define CTRL_ARM_STOP 1
`define CTRL_GATE_EXT 2
`define CTRL_COMMON 3
`define CTRL_FUNC_LO 4
`define CTRL_FUNC_HI 6
`define CTRL_SLOPE_ONE 7
`define CTRL_SLOPE_TWO 8
`define CTRL_WIDTH 9

// Command bits, write-only pulses
`define CMD_GO 0
`define CMD_ABORT 1
`define CMD_CAL 2

// Sticky status bits
`define STS_OPENED 0
`define STS_CLOSED 1
`define STS_ROLL 2
`define STS_DONE 3

// Reset values
`define RST_CTRL 9'h180
`define RST_GATE_TIME 32'h000f4240
`define RST_CAL_WIDTH 16'h0804

// Timing: reference and system clock periods
`define REF_PERIOD_NS 100
`define CLK_PERIOD_NS 10
`define REF_DIV_CYC (`REF_PERIOD_NS / `CLK_PERIOD_NS)
`define OPEN_PULSE_TICKS 2

`endif

// [pkg/gate_counter_pkg.sv]
package gate_counter_pkg;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_WAIT_OPEN = 7'h02,
      ST_GATE = 7'h04,
      ST_WAIT_CLOSE = 7'h08,
      ST_INTERP = 7'h10,
      ST_CAL = 7'h20,
      ST_DONE = 7'h40
   } gate_state_t;

   typedef enum logic [2:0] {
      FN_FREQ_ONE = 3'h0,
      FN_FREQ_TWO = 3'h1,
      FN_PERIOD_ONE = 3'h2,
      FN_PERIOD_TWO = 3'h3,
      FN_TI_ONE_TWO = 3'h4,
      FN_TI_TWO_ONE = 3'h5
   } meas_func_t;

endpackage

// [tb/edge_interp_model.sv]
`timescale 1ns/10ps
module edge_interp_model #(
   parameter int SLOW = 2
) (
   // Clock
   input wire logic pclk,
   // Charge pulse in, discharge indication out
   input wire logic charge,
   output logic discharge
);
   int level = 0;

   initial discharge = 1'b0;

   // Charge fast, bleed slower: discharge lasts SLOW times the pulse
   always @(posedge pclk) begin
      if (charge) begin
         level <= level + SLOW;
         discharge <= 1'b0;
      end else if (level > 0) begin
         level <= level - 1;
         discharge <= 1'b1;
      end else begin
         discharge <= 1'b0;
      end
   end
endmodule

// [tb/gate_counter_sva.sv]
`timescale 1ns/10ps
module gate_counter_sva (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Gate and pulses
   input wire logic gate_open,
   input wire logic start_pulse,
   input wire logic stop_pulse,
   input wire logic evt_gate_opened,
   input wire logic evt_gate_closed,
   input wire logic evt_done
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Steps of a transfer and of a measurement
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_open;
      $rose(gate_open);
   endsequence
   sequence s_close;
      $fell(gate_open);
   endsequence

   a_ready_access: assert property (s_setup |=> pready)
      else $error("no ready in access cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held past access cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   a_open_flags: assert property (s_open |-> evt_gate_opened && start_pulse)
      else $error("gate opened without event or start pulse");
   // Width runs to the second reference tick, so 11 to 20 cycles
   a_start_width: assert property (s_open |-> start_pulse[*8] ##1 start_pulse[*3] ##[1:10] !start_pulse)
      else $error("start pulse width out of range");
   a_close_flags: assert property (s_close |-> evt_gate_closed && stop_pulse)
      else $error("gate closed without event or stop pulse");
   a_stop_width: assert property (s_close |-> stop_pulse[*8] ##1 stop_pulse[*3] ##[1:10] !stop_pulse)
      else $error("stop pulse width out of range");
   a_opened_single: assert property (evt_gate_opened |=> !evt_gate_opened)
      else $error("open event longer than a cycle");
   a_done_single: assert property (evt_done |=> !evt_done && !gate_open)
      else $error("done event long or gate still open");
endmodule

bind reciprocal_gate_counter gate_counter_sva u_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .gate_open(gate_open),
   .start_pulse(start_pulse), .stop_pulse(stop_pulse),
   .evt_gate_opened(evt_gate_opened), .evt_gate_closed(evt_gate_closed),
   .evt_done(evt_done)
);

// [tb/reciprocal_gate_counter_tb_top.sv]
`timescale 1ns/10ps
`include "gate_counter_map.svh"
module reciprocal_gate_counter_tb_top;
   // Stimulus
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic input_one = 1'b0;
   logic input_two = 1'b0;
   logic ext_arm = 1'b1;
   logic run_one = 1'b0;
   logic rolled = 1'b0;
   // Observed
   logic [31:0] prdata, q, ev, rc;
   logic pready, pslverr, start_pulse, stop_pulse, gate_open, open_dis, close_dis;
   logic evt_gate_opened, evt_gate_closed, evt_rollover, evt_done, e, seen;
   int fail_count = 0;
   int n_compared = 0;
   int ph = 0;

   always #5 pclk = ~pclk;

   reciprocal_gate_counter #(.CNT_W(32)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .input_one(input_one),
      .input_two(input_two), .ext_arm(ext_arm), .open_discharge(open_dis),
      .close_discharge(close_dis), .start_pulse(start_pulse),
      .stop_pulse(stop_pulse), .gate_open(gate_open),
      .evt_gate_opened(evt_gate_opened), .evt_gate_closed(evt_gate_closed),
      .evt_rollover(evt_rollover), .evt_done(evt_done)
   );
   edge_interp_model u_open (.pclk(pclk), .charge(start_pulse), .discharge(open_dis));
   edge_interp_model u_close (.pclk(pclk), .charge(stop_pulse), .discharge(close_dis));

   // Channel one square wave, 16 cycles a period
   always @(posedge pclk) begin
      if (run_one) begin
         ph <= (ph + 1) % 8;
         if (ph == 7) begin
            input_one <= ~input_one;
         end
      end
   end

   // Any rollover event is remembered for the final check
   always @(posedge pclk) begin
      if (evt_rollover === 1'b1) begin
         rolled <= 1'b1;
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
      n_compared++;
      if (seen_v !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen_v);
      end
   endtask

   function automatic logic [31:0] inr(input logic [31:0] v, input int lo, input int hi);
      return {31'h0, (v >= lo && v <= hi)};
   endfunction

   // One transfer; hold everything until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rdat, output logic err);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         check("pready", {31'h0, pready}, 32'h1);
         report_and_stop();
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb(1'b1, a, d, x, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      apb(1'b0, a, 32'h0, d, e);
   endtask

   task automatic run(input logic [31:0] ctrl);
      wr(`OFS_CTRL, ctrl);
      wr(`OFS_CMD, 32'h00000001);
   endtask

   task automatic watch(input int n, output logic any);
      any = 1'b0;
      repeat (n) begin
         @(posedge pclk);
         any = any | gate_open;
      end
   endtask

   // Bounded wait for the one-cycle done event
   task automatic wait_done();
      int n;
      n = 0;
      while (evt_done !== 1'b1 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      check("done", {31'h0, evt_done}, 32'h1);
      if (evt_done !== 1'b1) begin
         report_and_stop();
      end
      @(posedge pclk);
   endtask

   // Gate spans whole input periods, so 16 * events matches 10 * ticks
   task automatic counts(input int lo, input int hi);
      rd(`OFS_EVENT_CNT, ev);
      rd(`OFS_REF_CNT, rc);
      check("events", inr(ev, lo, hi), 32'h1);
      check("ref ticks", inr(16 * ev + 20 - 10 * rc, 0, 40), 32'h1);
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values and an unmapped word
      rd(`OFS_CTRL, q);
      check("ctrl", q, 32'h00000180);
      rd(`OFS_GATE_TIME, q);
      check("gate time", q, 32'h000f4240);
      rd(`OFS_CAL_WIDTH, q);
      check("cal width", q, 32'h00000804);
      rd(`OFS_STATUS, q);
      check("status", q, 32'h00000100);
      apb(1'b0, 8'h40, 32'h0, q, e);
      check("slverr", {31'h0, e}, 32'h00000001);
      $display("test reset done");
      // No gate without start arm, nor from an idle channel two
      run_one <= 1'b1;
      wr(`OFS_GATE_TIME, 32'h00000005);
      run(32'h00000182);
      watch(150, seen);
      check("open unarmed", {31'h0, seen}, 32'h0);
      wr(`OFS_CMD, 32'h00000002);
      run(32'h00000193);
      watch(150, seen);
      check("open idle two", {31'h0, seen}, 32'h0);
      wr(`OFS_CMD, 32'h00000002);
      $display("test arming done");
      // Internal gate on channel one, then hold and clear
      run(32'h00000183);
      wait_done();
      rd(`OFS_STATUS, q);
      check("status done", q & 32'h00007f0f, 32'h0000400b);
      counts(3, 5);
      rd(`OFS_OPEN_TALLY, q);
      check("open tally", inr(q, 14, 46), 32'h1);
      rd(`OFS_CLOSE_TALLY, q);
      check("close tally", inr(q, 14, 46), 32'h1);
      repeat (100) @(posedge pclk);
      rd(`OFS_EVENT_CNT, q);
      check("events held", q, ev);
      wr(`OFS_STATUS, 32'h0000000f);
      rd(`OFS_STATUS, q);
      check("status clear", q & 32'h0000000f, 32'h0);
      $display("test internal gate done");
      // Common mode feeds channel one to channel two
      run(32'h0000019b);
      wait_done();
      counts(3, 5);
      $display("test common mode done");
      // External gate ends only when the arm input drops
      run(32'h00000187);
      repeat (120) @(posedge pclk);
      check("ext gate open", {31'h0, gate_open}, 32'h1);
      ext_arm <= 1'b0;
      wait_done();
      counts(6, 10);
      ext_arm <= 1'b1;
      $display("test external gate done");
      // Time interval: channel one opens, channel two closes 60 cycles on
      run_one <= 1'b0;
      input_one <= 1'b0;
      repeat (20) @(posedge pclk);
      run(32'h000001c3);
      repeat (20) @(posedge pclk);
      input_one <= 1'b1;
      repeat (60) @(posedge pclk);
      input_two <= 1'b1;
      wait_done();
      rd(`OFS_REF_CNT, q);
      check("interval ticks", inr(q, 5, 7), 32'h1);
      $display("test interval done");
      // Calibration with widths of 2 and 5 ticks
      wr(`OFS_CAL_WIDTH, 32'h00000502);
      wr(`OFS_CMD, 32'h00000004);
      wait_done();
      for (int i = 0; i < 4; i++) begin
         rd(`OFS_CAL_BASE + 8'(4 * i), q);
         check("cal tally", inr(q, i < 2 ? 16 : 76, i < 2 ? 46 : 106), 32'h1);
      end
      check("rollover", {31'h0, rolled}, 32'h0);
      $display("test calibration done");
      report_and_stop();
   end
endmodule
